/* File: logic/usart_ctrl.sv */
// Serial transceiver control, status and baud divider with its bit engines
//
// Decided for this implementation: the plain strobed port.
`include "usart_ctrl_map.svh"
`default_nettype none

// Notes on behaviour
// - Sync: clock source 1 master, 0 slave.
// - Transmit width bit picks nine or eight.
// - Transmit enable; sync receive enables take precedence.
// - Mode bit: sync half duplex or async.
// - High speed divider only in async mode.
// - Shift register empty status, resets to one.
// - Ninth transmitted bit from control bit.
// - Pins serve port only with directions set.
// - Receive width bit picks nine or eight.
// - Single receive in master, cleared when done.
// - Framing flag updated with each delivered character.
// - Overrun flag set; cleared by clearing continuous.
// - Ninth received bit held in status.
// - Dedicated free-running eight bit divider timer.
// - Rates: 64, 16 or 4 times divisor+1.
// - Divisor spans zero through 255.
// - Slave bit timing follows external clock.
// - Divisor write restarts the timer at once.
// - Bit 3 of both status registers reads zero.
// - Async, sync master, sync slave modes.
module usart_ctrl (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire usart_ctrl_pkg::bus_req_type   bus,
  input  wire logic [1:0]                    port_direction_bits,
  input  wire logic                          dt_pin_in,
  input  wire logic                          ck_pin_in,
  output var  logic [7:0]                    rdata,
  output var  usart_ctrl_pkg::pin_drive_type pins
);

  usart_ctrl_pkg::state_type st;
  usart_ctrl_pkg::state_type n;
  logic                      baud_tick;
  logic                      port_active;
  logic                      master;
  logic                      sync;
  logic                      nine_tx;
  logic                      nine_rx;
  logic                      rx_req;
  logic                      rx_on;
  logic                      tx_on;
  logic                      rise;
  logic                      fall;
  logic                      done;
  logic                      done_framing_error_flag;
  logic [6:0]                bit_len;
  logic [8:0]                shifted;

  always_comb begin
    n = st;
    n.rdata = 8'h00;
    done = 1'b0;
    done_framing_error_flag = 1'b0;
    shifted = st.rx_shift;
    rise = 1'b0;
    fall = 1'b0;
    n.dt_meta = dt_pin_in;
    n.dt_sync = st.dt_meta;
    n.ck_meta = ck_pin_in;
    n.ck_sync = st.ck_meta;
    n.ck_prev = st.ck_sync;

    // Divider ticks once every divisor+1 cycles, any divisor value
    baud_tick = (st.baud_count == 8'h00);
    n.baud_count = baud_tick ? st.baud_divisor : st.baud_count - 8'h01;

    port_active = st.rxc.serial_port_enable && (port_direction_bits == 2'h3);
    sync = st.txc.sync_mode;
    master = sync && st.txc.clock_source_select;
    nine_tx = st.txc.tx_nine_bit_select;
    nine_rx = st.rxc.rx_nine_bit_select;
    if (sync) begin
      rx_req = st.rxc.continuous_receive_enable ||
               (master && st.rxc.single_receive_enable);
    end else begin
      rx_req = st.rxc.continuous_receive_enable;
    end
    rx_req = rx_req && port_active;
    // Reception halts while an overrun is pending
    rx_on = rx_req && !st.rxc.overrun_error_flag;
    tx_on = port_active && st.txc.transmit_enable_bit && !(sync && rx_req);
    bit_len = st.txc.high_speed_divider_select ? `ASYNC_HIGH_TICKS : `ASYNC_LOW_TICKS;

    // Sync bit clock: internal in master, pin edges in slave
    if (master) begin
      if (st.tx_state == usart_ctrl_pkg::TX_SHIFT || st.rx_state == usart_ctrl_pkg::RX_DATA) begin
        if (baud_tick) begin
          if (st.ck_phase == 7'h00) begin
            n.ck_phase = `SYNC_HALF_TICKS - 7'h01;
            n.ck_level = !st.ck_level;
            rise = !st.ck_level;
            fall = st.ck_level;
          end else begin
            n.ck_phase = st.ck_phase - 7'h01;
          end
        end
      end else begin
        n.ck_level = 1'b0;
        n.ck_phase = `SYNC_HALF_TICKS - 7'h01;
      end
    end else begin
      rise = st.ck_sync && !st.ck_prev;
      fall = !st.ck_sync && st.ck_prev;
      n.ck_level = 1'b0;
    end

    case (st.tx_state)
      usart_ctrl_pkg::TX_IDLE: begin
        if (tx_on && st.tx_buf_full) begin
          n.tx_buf_full = 1'b0;
          n.tx_state = usart_ctrl_pkg::TX_SHIFT;
          n.tx_phase = bit_len - 7'h01;
          if (sync) begin
            n.tx_shift = {2'h3, st.txc.tx_ninth_bit, st.tx_buf};
            n.tx_bits = nine_tx ? `NINE_DATA_BITS : `EIGHT_DATA_BITS;
          end else begin
            // Stop, ninth or stop-filler, data, start
            n.tx_shift = {1'b1, nine_tx ? st.txc.tx_ninth_bit : 1'b1, st.tx_buf, 1'b0};
            n.tx_bits = nine_tx ? `ASYNC_FRAME9 : `ASYNC_FRAME8;
          end
        end
      end
      usart_ctrl_pkg::TX_SHIFT: begin
        if (!tx_on) begin
          n.tx_state = usart_ctrl_pkg::TX_IDLE;
        end else if (sync ? fall : (baud_tick && st.tx_phase == 7'h00)) begin
          n.tx_phase = bit_len - 7'h01;
          n.tx_shift = {1'b1, st.tx_shift[10:1]};
          n.tx_bits = st.tx_bits - 4'h1;
          if (st.tx_bits == 4'h1) begin
            n.tx_state = usart_ctrl_pkg::TX_IDLE;
          end
        end else if (!sync && baud_tick) begin
          n.tx_phase = st.tx_phase - 7'h01;
        end
      end
      default: begin
        n.tx_state = usart_ctrl_pkg::TX_IDLE;
      end
    endcase

    case (st.rx_state)
      usart_ctrl_pkg::RX_IDLE: begin
        if (rx_on && sync) begin
          n.rx_state = usart_ctrl_pkg::RX_DATA;
          n.rx_bits = nine_rx ? `NINE_DATA_BITS : `EIGHT_DATA_BITS;
        end else if (rx_on && !st.dt_sync) begin
          n.rx_state = usart_ctrl_pkg::RX_START;
          n.rx_phase = (bit_len >> 1) - 7'h01;
        end
      end
      usart_ctrl_pkg::RX_START: begin
        if (!rx_on) begin
          n.rx_state = usart_ctrl_pkg::RX_IDLE;
        end else if (baud_tick) begin
          if (st.rx_phase != 7'h00) begin
            n.rx_phase = st.rx_phase - 7'h01;
          end else if (st.dt_sync) begin
            // Glitch, not a start bit
            n.rx_state = usart_ctrl_pkg::RX_IDLE;
          end else begin
            n.rx_state = usart_ctrl_pkg::RX_DATA;
            n.rx_phase = bit_len - 7'h01;
            n.rx_bits = nine_rx ? `NINE_DATA_BITS : `EIGHT_DATA_BITS;
          end
        end
      end
      usart_ctrl_pkg::RX_DATA: begin
        if (!rx_on) begin
          n.rx_state = usart_ctrl_pkg::RX_IDLE;
        end else if (sync ? rise : (baud_tick && st.rx_phase == 7'h00)) begin
          shifted = {st.dt_sync, st.rx_shift[8:1]};
          n.rx_shift = shifted;
          n.rx_bits = st.rx_bits - 4'h1;
          n.rx_phase = bit_len - 7'h01;
          if (st.rx_bits == 4'h1) begin
            if (sync) begin
              done = 1'b1;
              n.rx_state = usart_ctrl_pkg::RX_IDLE;
            end else begin
              n.rx_state = usart_ctrl_pkg::RX_STOP;
            end
          end
        end else if (!sync && baud_tick) begin
          n.rx_phase = st.rx_phase - 7'h01;
        end
      end
      usart_ctrl_pkg::RX_STOP: begin
        if (!rx_on) begin
          n.rx_state = usart_ctrl_pkg::RX_IDLE;
        end else if (baud_tick) begin
          if (st.rx_phase == 7'h00) begin
            done = 1'b1;
            done_framing_error_flag = !st.dt_sync;
            n.rx_state = usart_ctrl_pkg::RX_IDLE;
          end else begin
            n.rx_phase = st.rx_phase - 7'h01;
          end
        end
      end
      default: begin
        n.rx_state = usart_ctrl_pkg::RX_IDLE;
      end
    endcase

    if (bus.wr) begin
      case (bus.addr)
        `TX_CS_ADDR: begin
          n.txc = {bus.wdata[7:4], 1'b0, bus.wdata[2], st.txc.shift_reg_empty, bus.wdata[0]};
        end
        `RX_CS_ADDR: begin
          n.rxc = {bus.wdata[7:4], 1'b0, st.rxc[2:0]};
          if (!bus.wdata[4]) begin
            n.rxc.overrun_error_flag = 1'b0;
          end
        end
        `BAUD_ADDR: begin
          n.baud_divisor = bus.wdata;
          n.baud_count = bus.wdata;
        end
        `TX_DATA_ADDR: begin
          n.tx_buf = bus.wdata;
          n.tx_buf_full = 1'b1;
        end
        default: begin
        end
      endcase
    end

    if (bus.rd) begin
      case (bus.addr)
        `TX_CS_ADDR:     n.rdata = st.txc;
        `RX_CS_ADDR:     n.rdata = st.rxc;
        `BAUD_ADDR:      n.rdata = st.baud_divisor;
        `DATA_STAT_ADDR: n.rdata = {6'h00, !st.tx_buf_full, st.rx_full};
        `RX_DATA_ADDR: begin
          n.rdata = st.rx_hold;
          n.rx_full = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Delivery after the bus so a new event beats a same-cycle clear
    if (done) begin
      if (n.rx_full) begin
        n.rxc.overrun_error_flag = 1'b1;
      end else begin
        n.rx_hold = nine_rx ? shifted[7:0] : shifted[8:1];
        n.rxc.rx_ninth_bit = nine_rx & shifted[8];
        n.rxc.framing_error_flag = done_framing_error_flag;
        n.rx_full = 1'b1;
      end
      if (master && !st.rxc.continuous_receive_enable) begin
        n.rxc.single_receive_enable = 1'b0;
      end
    end

    n.txc.shift_reg_empty = (n.tx_state == usart_ctrl_pkg::TX_IDLE);

    // Async: clock pin carries transmit line, data pin is receive input
    n.pins.ck_oe = port_active && (!n.txc.sync_mode || n.txc.clock_source_select);
    n.pins.ck_out = n.txc.sync_mode ? n.ck_level :
                    (n.tx_state == usart_ctrl_pkg::TX_IDLE || n.tx_shift[0]);
    n.pins.dt_oe = port_active && n.txc.sync_mode && (n.tx_state == usart_ctrl_pkg::TX_SHIFT);
    n.pins.dt_out = n.tx_shift[0];

    if (!rst_n) begin
      n = '0;
      n.txc = `TX_CS_RESET;
      n.rxc = `RX_CS_RESET;
      n.baud_divisor = `BAUD_RESET;
      n.tx_state = usart_ctrl_pkg::TX_IDLE;
      n.rx_state = usart_ctrl_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    st <= n;
  end

  assign rdata = st.rdata;
  assign pins = st.pins;

  a_shift_empty_read : assert property (
    @(posedge clock) disable iff (!rst_n)
    bus.rd && bus.addr == `TX_CS_ADDR && st.tx_state == usart_ctrl_pkg::TX_IDLE |=> rdata[1])
    else $error("Idle transmitter reads back as full");

  a_gap_bits_zero : assert property (
    @(posedge clock) disable iff (!rst_n)
    bus.rd && (bus.addr == `TX_CS_ADDR || bus.addr == `RX_CS_ADDR) |=> rdata[3] == 1'b0)
    else $error("Unimplemented status bit reads as one");

  a_divisor_restart : assert property (
    @(posedge clock) disable iff (!rst_n)
    bus.wr && bus.addr == `BAUD_ADDR |=> st.baud_count == $past(bus.wdata))
    else $error("Divisor write did not restart the timer");

  a_baud_countdown : assert property (
    @(posedge clock) disable iff (!rst_n)
    st.baud_count != 8'h00 && !(bus.wr && bus.addr == `BAUD_ADDR)
    |=> st.baud_count == $past(st.baud_count) - 8'h01)
    else $error("Divider timer did not count down");

  a_baud_wrap : assert property (
    @(posedge clock) disable iff (!rst_n)
    st.baud_count == 8'h00 && !(bus.wr && bus.addr == `BAUD_ADDR)
    |=> st.baud_count == $past(st.baud_divisor))
    else $error("Divider timer did not reload from divisor");

  a_pins_released : assert property (
    @(posedge clock) disable iff (!rst_n)
    !port_active |=> !pins.ck_oe && !pins.dt_oe)
    else $error("Pin driven while serial port disabled");

  a_rx_precedence : assert property (
    @(posedge clock) disable iff (!rst_n)
    sync && rx_req |=> st.tx_state == usart_ctrl_pkg::TX_IDLE)
    else $error("Sync transmit started during receive");

  a_single_cleared : assert property (
    @(posedge clock) disable iff (!rst_n)
    done && master && !st.rxc.continuous_receive_enable
    |=> !st.rxc.single_receive_enable)
    else $error("Single receive left set after reception");

  a_start_bit_low : assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(st.tx_state == usart_ctrl_pkg::TX_SHIFT) && !st.txc.sync_mode |-> pins.ck_out == 1'b0)
    else $error("Async frame did not open with a low start bit");

  a_overrun_set : assert property (
    @(posedge clock) disable iff (!rst_n)
    done && st.rx_full && !(bus.rd && bus.addr == `RX_DATA_ADDR) |=> st.rxc.overrun_error_flag)
    else $error("Overrun not flagged");

endmodule

`default_nettype wire

/* File: logic/usart_ctrl_map.svh */
// Register offsets, reset values and timing counts of the serial transceiver control block
`ifndef USART_CTRL_MAP_SVH
`define USART_CTRL_MAP_SVH

// Register offsets
`define RX_CS_ADDR        8'h18
`define TX_CS_ADDR        8'h98
`define BAUD_ADDR         8'h99
`define TX_DATA_ADDR      8'h19
`define RX_DATA_ADDR      8'h1A
`define DATA_STAT_ADDR    8'h1B

// Reset values
`define TX_CS_RESET       8'h02
`define RX_CS_RESET       8'h00
`define BAUD_RESET        8'h00

// Divider ticks per bit
`define ASYNC_LOW_TICKS   7'h40
`define ASYNC_HIGH_TICKS  7'h10
`define SYNC_TICKS        7'h04
`define SYNC_HALF_TICKS   (`SYNC_TICKS >> 1)

// Bit counts per character
`define EIGHT_DATA_BITS   4'h8
`define NINE_DATA_BITS    4'h9
`define ASYNC_FRAME8      4'hA
`define ASYNC_FRAME9      4'hB

`endif

/* File: logic/usart_ctrl_pkg.sv */
// Types shared by the serial transceiver control block
`default_nettype none

package usart_ctrl_pkg;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'h1,
    TX_SHIFT = 2'h2
  } tx_state_type;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  typedef struct packed {
    logic ck_out;
    logic ck_oe;
    logic dt_out;
    logic dt_oe;
  } pin_drive_type;

  // Bit 7 first, matching the register layout
  typedef struct packed {
    logic clock_source_select;
    logic tx_nine_bit_select;
    logic transmit_enable_bit;
    logic sync_mode;
    logic gap;
    logic high_speed_divider_select;
    logic shift_reg_empty;
    logic tx_ninth_bit;
  } tx_cs_type;

  typedef struct packed {
    logic serial_port_enable;
    logic rx_nine_bit_select;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic gap;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic rx_ninth_bit;
  } rx_cs_type;

  typedef struct packed {
    tx_cs_type     txc;
    rx_cs_type     rxc;
    logic [7:0]    baud_divisor;
    logic [7:0]    baud_count;
    logic [7:0]    tx_buf;
    logic          tx_buf_full;
    tx_state_type  tx_state;
    logic [10:0]   tx_shift;
    logic [3:0]    tx_bits;
    logic [6:0]    tx_phase;
    rx_state_type  rx_state;
    logic [8:0]    rx_shift;
    logic [3:0]    rx_bits;
    logic [6:0]    rx_phase;
    logic [7:0]    rx_hold;
    logic          rx_full;
    logic          ck_level;
    logic [6:0]    ck_phase;
    logic          dt_meta;
    logic          dt_sync;
    logic          ck_meta;
    logic          ck_sync;
    logic          ck_prev;
    logic [7:0]    rdata;
    pin_drive_type pins;
  } state_type;

endpackage

`default_nettype wire

/* File: verification/peer.sv */
// Remote serial peer: frames bytes onto the data pin and decodes the clock/transmit pin
`default_nettype none
module peer (
  input  wire logic clock,
  input  wire logic ck_line,
  input  wire logic dt_line,
  output var  logic dt_drive,
  output var  logic ck_drive
);
  timeunit 1ns;
  timeprecision 100ps;
  // Peer idles the data line high, so a released line sits high
  initial begin
    dt_drive = 1'b1;
    ck_drive = 1'b0;
  end
  // A low stop is cut short so the receiver cannot take its tail for a new start
  task automatic send_async(input logic [8:0] d, input int n, input logic stop, input int bc);
    @(posedge clock);
    for (int i = 0; i <= n + 1; i++) begin
      dt_drive <= (i == 0) ? 1'b0 : (i == n + 1) ? stop : d[i-1];
      repeat ((i == n + 1 && !stop) ? bc / 2 + 2 : bc) @(posedge clock);
    end
    dt_drive <= 1'b1;
  endtask
  task automatic get_async(output logic [8:0] d, output logic stop, input int n, input int bc);
    d = '0;
    @(negedge ck_line);
    repeat (bc / 2) @(negedge clock);
    for (int i = 0; i <= n; i++) begin
      repeat (bc) @(negedge clock);
      if (i < n) d[i] = ck_line;
      else stop = ck_line;
    end
  endtask
  task automatic get_sync(output logic [7:0] d, output realtime per);
    realtime t0;
    for (int i = 0; i < 8; i++) begin
      @(posedge ck_line);
      d[i] = dt_line;
      if (i == 0) t0 = $realtime;
      if (i == 1) per = $realtime - t0;
    end
  endtask
  // Next bit goes out on each falling bit clock, clear of the rising sample
  task automatic reply_sync(input logic [7:0] d);
    dt_drive <= d[0];
    for (int i = 1; i < 8; i++) begin
      @(negedge ck_line);
      dt_drive <= d[i];
    end
    @(posedge ck_line);
    repeat (8) @(posedge clock);
    dt_drive <= 1'b1;
  endtask
  // Slave bit clock at 125 ns, still outside the frame
  task automatic send_slave(input logic [7:0] d);
    #1.3;
    for (int i = 0; i < 8; i++) begin
      dt_drive <= d[i];
      #62.5 ck_drive <= 1'b1;
      #62.5 ck_drive <= 1'b0;
    end
    #62.5 dt_drive <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the serial transceiver control block
`include "usart_ctrl_map.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                          clock;
  logic                          rst_n;
  usart_ctrl_pkg::bus_req_type   bus;
  logic [1:0]                    port_direction_bits;
  logic [7:0]                    rdata;
  usart_ctrl_pkg::pin_drive_type pins;
  logic                          peer_dt;
  logic                          peer_ck;
  wire  logic                    dt_wire;
  wire  logic                    ck_wire;
  int                            n_fail;
  int                            check_count;
  logic [8:0]                    got;
  logic                          stop;
  realtime                       per;

  // Pin level resolved from the block's enable; the peer drives the pin otherwise
  assign dt_wire = pins.dt_oe ? pins.dt_out : peer_dt;
  assign ck_wire = pins.ck_oe ? pins.ck_out : peer_ck;

  usart_ctrl i_usart_ctrl (.clock(clock), .rst_n(rst_n), .bus(bus),
    .port_direction_bits(port_direction_bits), .dt_pin_in(dt_wire), .ck_pin_in(ck_wire),
    .rdata(rdata), .pins(pins));
  peer i_peer (.clock(clock), .ck_line(ck_wire), .dt_line(dt_wire), .dt_drive(peer_dt),
    .ck_drive(peer_ck));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    @(negedge clock);
    check(16'(rdata), 16'(exp));
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic t_regs();
    rchk(`TX_CS_ADDR, `TX_CS_RESET);
    rchk(`RX_CS_ADDR, `RX_CS_RESET);
    rchk(`BAUD_ADDR, `BAUD_RESET);
    rchk(8'h55, 8'h00);
    wr(`BAUD_ADDR, 8'hFF);
    rchk(`BAUD_ADDR, 8'hFF);
    wr(`TX_CS_ADDR, 8'hFF);
    rchk(`TX_CS_ADDR, 8'hF7);
    wr(`TX_CS_ADDR, 8'h00);
    wr(`RX_CS_ADDR, 8'h6F);
    rchk(`RX_CS_ADDR, 8'h60);
    wr(`RX_CS_ADDR, 8'h00);
  endtask
  task automatic t_port();
    @(posedge clock);
    port_direction_bits <= 2'h1;
    wr(`RX_CS_ADDR, 8'h80);
    wr(`TX_CS_ADDR, 8'h24);
    repeat (3) @(posedge clock);
    @(negedge clock);
    check(16'(pins.ck_oe), 16'h0000);
    @(posedge clock);
    port_direction_bits <= 2'h3;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check(16'({pins.ck_oe, pins.ck_out}), 16'h0003);
  endtask
  task automatic t_atx(input logic [7:0] dv, input logic [7:0] cs, input logic [8:0] d,
                       input int n, input int bc);
    fork
      i_peer.get_async(got, stop, n, bc);
      begin
        wr(`BAUD_ADDR, dv);
        wr(`TX_CS_ADDR, cs);
        wr(`TX_DATA_ADDR, d[7:0]);
        rchk(`TX_CS_ADDR, cs);
      end
    join
    check(16'(got), 16'(d));
    check(16'(stop), 16'h0001);
    repeat (bc) @(posedge clock);
    rchk(`TX_CS_ADDR, cs | 8'h02);
  endtask
  task automatic t_arx();
    wr(`TX_CS_ADDR, 8'h04);
    wr(`RX_CS_ADDR, 8'h90);
    i_peer.send_async(9'h05A, 8, 1'b1, 16);
    rchk(`DATA_STAT_ADDR, 8'h03);
    rchk(`RX_DATA_ADDR, 8'h5A);
    rchk(`RX_CS_ADDR, 8'h90);
    i_peer.send_async(9'h00F, 8, 1'b0, 16);
    rchk(`RX_DATA_ADDR, 8'h0F);
    rchk(`RX_CS_ADDR, 8'h94);
    i_peer.send_async(9'h011, 8, 1'b1, 16);
    rchk(`RX_CS_ADDR, 8'h90);
    rchk(`RX_DATA_ADDR, 8'h11);
    i_peer.send_async(9'h022, 8, 1'b1, 16);
    i_peer.send_async(9'h033, 8, 1'b1, 16);
    rchk(`RX_CS_ADDR, 8'h92);
    rchk(`RX_DATA_ADDR, 8'h22);
    wr(`RX_CS_ADDR, 8'h80);
    rchk(`RX_CS_ADDR, 8'h80);
    wr(`RX_CS_ADDR, 8'hD0);
    i_peer.send_async(9'h1A5, 9, 1'b1, 16);
    rchk(`RX_CS_ADDR, 8'hD1);
    rchk(`RX_DATA_ADDR, 8'hA5);
    // Low speed receive, the setting software is advised to keep
    wr(`TX_CS_ADDR, 8'h00);
    wr(`RX_CS_ADDR, 8'h90);
    i_peer.send_async(9'h0C6, 8, 1'b1, 64);
    rchk(`RX_DATA_ADDR, 8'hC6);
  endtask
  task automatic t_sync();
    wr(`RX_CS_ADDR, 8'h80);
    wr(`BAUD_ADDR, 8'h03);
    wr(`TX_CS_ADDR, 8'hB4);
    fork
      i_peer.get_sync(got[7:0], per);
      wr(`TX_DATA_ADDR, 8'h5A);
    join
    check(16'(got[7:0]), 16'h005A);
    check(16'(int'(per)), 16'h0040);
    repeat (20) @(posedge clock);
    fork
      i_peer.reply_sync(8'hC3);
      wr(`RX_CS_ADDR, 8'hA0);
    join
    rchk(`RX_CS_ADDR, 8'h80);
    rchk(`RX_DATA_ADDR, 8'hC3);
    wr(`TX_CS_ADDR, 8'h10);
    wr(`RX_CS_ADDR, 8'h90);
    repeat (3) @(posedge clock);
    @(negedge clock);
    check(16'(pins.ck_oe), 16'h0000);
    i_peer.send_slave(8'h6B);
    repeat (10) @(posedge clock);
    rchk(`RX_DATA_ADDR, 8'h6B);
  endtask

  initial begin
    rst_n = 1'b0;
    bus = '0;
    port_direction_bits = 2'h3;
    n_fail = 0;
    check_count = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_port();
    t_atx(8'h00, 8'h24, 9'h0A5, 8, 16);
    t_atx(8'h02, 8'h24, 9'h03C, 8, 48);
    t_atx(8'h01, 8'h20, 9'h096, 8, 128);
    t_atx(8'h00, 8'h65, 9'h1C3, 9, 16);
    t_atx(8'h00, 8'h64, 9'h0C3, 9, 16);
    t_arx();
    t_sync();
    wrap_up();
  end
  // Whole run is near 5000 cycles
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
